//--- verilog/ald_core.sv
// How it works
// - add-accumulator-to-file adds the accumulator to the addressed memory byte.
// - destination bit 0 writes the accumulator, 1 writes back to memory.
// - add-with-carry sums accumulator, carry flag and memory byte, then routes it.
// - bank bit 0 uses the access bank, 1 uses the bank select register.
// - extended set, bank bit 0, address up to 5Fh: indexed literal offset.
// - and-literal ANDs the literal into the accumulator.
// - add-literal adds the literal into the accumulator.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "ald_regs.svh"

module ald_core
  import ald_pkg::*;
#(
  parameter int MEM_ADDR_W = 12
) (
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O
);

  // ********************************************************
  // elaboration check
  // ********************************************************
  // effective addresses are 12 bits, the bank field is 4 bits
  if (MEM_ADDR_W < 8 || MEM_ADDR_W > 12) begin : g_bad_width
    $error("MEM_ADDR_W must lie between 8 and 12");
  end

  // ********************************************************
  // state
  // ********************************************************
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [7:0] acc_r, acc_nxt;
  ald_flags_s flg_r, flg_nxt;
  logic [3:0] bank_r, bank_nxt;
  logic ext_r, ext_nxt;
  logic [11:0] ibase_r, ibase_nxt;
  logic [11:0] mptr_r, mptr_nxt;
  logic [15:0] instr_r, instr_nxt;
  logic [11:0] ea_r, ea_nxt;
  logic bad_r, bad_nxt;

  logic req, rd_req, wr_done, exec, is_reg;
  logic [7:0] adr;
  logic [31:0] rd_word, wr_word, ins_word;
  logic [15:0] cur_ins;
  logic [7:0] fld;
  logic [11:0] ea;
  ald_op_e op_dec;

  ald_alu_if alu_if ();
  ald_mem_if #(.ADDR_W(MEM_ADDR_W)) mem_if ();

  ald_alu u_alu (
    .alu(alu_if.alu)
  );

  ald_file_mem #(.ADDR_W(MEM_ADDR_W)) u_mem (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .mem(mem_if.mem)
  );

  // byte lanes not selected keep the old contents
  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ********************************************************
  // bus decode
  // ********************************************************
  // writes land on the ack edge, reads are sampled on the request edge
  assign req = CYC_I && STB_I;
  assign rd_req = req && !ack_r && !WE_I;
  assign wr_done = req && WE_I && ack_r;
  assign adr = {ADR_I[7:2], 2'b00};
  assign exec = wr_done && (adr == `ALD_ADR_INSTR);
  assign wr_word = merge_lanes(rd_word, DAT_I, SEL_I);
  assign ins_word = merge_lanes({16'h0000, instr_r}, DAT_I, SEL_I);

  // the executing word, or the last one so its address stays visible
  assign cur_ins = exec ? ins_word[15:0] : instr_r;
  assign fld = cur_ins[7:0];

  // ********************************************************
  // instruction decode and operand address
  // ********************************************************
  // unknown words decode to none and are only reported
  always_comb begin
    op_dec = ALD_OP_NONE;
    if (cur_ins[15:8] == `ALD_OPC_ADD_LITERAL_TO_ACCUMULATOR) begin
      op_dec = ALD_OP_ADD_LITERAL_TO_ACCUMULATOR;
    end else if (cur_ins[15:8] == `ALD_OPC_AND_LITERAL_WITH_ACCUMULATOR) begin
      op_dec = ALD_OP_AND_LITERAL_WITH_ACCUMULATOR;
    end else if (cur_ins[15:10] == `ALD_OPC_ADD_ACCUMULATOR_TO_FILE) begin
      op_dec = ALD_OP_ADD_ACCUMULATOR_TO_FILE;
    end else if (cur_ins[15:10] == `ALD_OPC_ADD_ACCUMULATOR_FILE_WITH_CARRY) begin
      op_dec = ALD_OP_ADD_ACCUMULATOR_FILE_WITH_CARRY;
    end
  end

  assign is_reg = (op_dec == ALD_OP_ADD_ACCUMULATOR_TO_FILE)
                  || (op_dec == ALD_OP_ADD_ACCUMULATOR_FILE_WITH_CARRY);

  // bank bit picks banked or access addressing
  always_comb begin
    if (cur_ins[`ALD_INS_BANKSEL_BIT]) begin
      ea = {bank_r, fld};
    end else if (ext_r && fld <= `ALD_ILO_MAX) begin
      ea = ibase_r + {4'h0, fld};
    end else if (fld <= `ALD_ILO_MAX) begin
      ea = {`ALD_ACCESS_LO_BANK, fld};
    end else begin
      ea = {`ALD_ACCESS_HI_BANK, fld};
    end
  end

  // ********************************************************
  // datapath hookup
  // ********************************************************
  // the window register borrows the read port only while it is addressed
  assign mem_if.rd_addr = (req && adr == `ALD_ADR_MDATA) ? mptr_r[MEM_ADDR_W-1:0]
                                                         : ea[MEM_ADDR_W-1:0];
  assign alu_if.op = op_dec;
  assign alu_if.acc = acc_r;
  assign alu_if.opnd = is_reg ? mem_if.rd_data : fld;
  assign alu_if.flags_in = flg_r;

  // ********************************************************
  // register read mux
  // ********************************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    case (adr)
      `ALD_ADR_INSTR: rd_word = {16'h0000, instr_r};
      `ALD_ADR_ACCUM: rd_word = {24'h00_0000, acc_r};
      `ALD_ADR_STATUS: rd_word = {27'h000_0000, flg_r};
      `ALD_ADR_BANK: rd_word = {28'h000_0000, bank_r};
      `ALD_ADR_CTRL: rd_word[`ALD_CTRL_EXT_BIT] = ext_r;
      `ALD_ADR_IBASE: rd_word = {20'h0_0000, ibase_r};
      `ALD_ADR_MPTR: rd_word = {20'h0_0000, mptr_r};
      `ALD_ADR_MDATA: rd_word = {24'h00_0000, mem_if.rd_data};
      `ALD_ADR_INFO: begin
        rd_word[11:0] = ea_r;
        rd_word[`ALD_INFO_BAD_BIT] = bad_r;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // ********************************************************
  // next state
  // ********************************************************
  // one bus write to the instruction register is one instruction cycle
  always_comb begin
    ack_nxt = req && !ack_r;
    dat_nxt = rd_req ? rd_word : dat_r;
    acc_nxt = acc_r;
    flg_nxt = flg_r;
    bank_nxt = bank_r;
    ext_nxt = ext_r;
    ibase_nxt = ibase_r;
    mptr_nxt = mptr_r;
    instr_nxt = instr_r;
    ea_nxt = ea_r;
    bad_nxt = bad_r;
    mem_if.wr_en = 1'b0;
    mem_if.wr_addr = ea[MEM_ADDR_W-1:0];
    mem_if.wr_data = alu_if.result;
    if (wr_done) begin
      case (adr)
        `ALD_ADR_INSTR: begin
          instr_nxt = ins_word[15:0];
          bad_nxt = (op_dec == ALD_OP_NONE);
          if (op_dec != ALD_OP_NONE) begin
            flg_nxt = alu_if.flags_out;
            ea_nxt = is_reg ? ea : ea_r;
            if (is_reg && cur_ins[`ALD_INS_DEST_BIT]) begin
              mem_if.wr_en = 1'b1;
            end else begin
              acc_nxt = alu_if.result;
            end
          end
        end
        `ALD_ADR_ACCUM: acc_nxt = wr_word[7:0];
        `ALD_ADR_STATUS: flg_nxt = wr_word[4:0];
        `ALD_ADR_BANK: bank_nxt = wr_word[3:0];
        `ALD_ADR_CTRL: ext_nxt = wr_word[`ALD_CTRL_EXT_BIT];
        `ALD_ADR_IBASE: ibase_nxt = wr_word[11:0];
        `ALD_ADR_MPTR: mptr_nxt = wr_word[11:0];
        `ALD_ADR_MDATA: begin
          mem_if.wr_en = 1'b1;
          mem_if.wr_addr = mptr_r[MEM_ADDR_W-1:0];
          mem_if.wr_data = wr_word[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ********************************************************
  // registers
  // ********************************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      acc_r <= `ALD_RST_ACCUM;
      flg_r <= `ALD_RST_STATUS;
      bank_r <= `ALD_RST_BANK;
      ext_r <= 1'b0;
      ibase_r <= `ALD_RST_IBASE;
      mptr_r <= 12'h000;
      instr_r <= `ALD_RST_INSTR;
      ea_r <= 12'h000;
      bad_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      acc_r <= acc_nxt;
      flg_r <= flg_nxt;
      bank_r <= bank_nxt;
      ext_r <= ext_nxt;
      ibase_r <= ibase_nxt;
      mptr_r <= mptr_nxt;
      instr_r <= instr_nxt;
      ea_r <= ea_nxt;
      bad_r <= bad_nxt;
    end
  end

  assign ACK_O = ack_r;
  assign DAT_O = dat_r;

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  property p_add_file;
    exec && op_dec == ALD_OP_ADD_ACCUMULATOR_TO_FILE && cur_ins[`ALD_INS_DEST_BIT]
      |=> mem_if.rd_data == 8'($past(acc_r) + $past(mem_if.rd_data));
  endproperty
  a_add_file: assert property (p_add_file) else $error("file sum wrong");

  property p_dest_w;
    exec && is_reg && !cur_ins[`ALD_INS_DEST_BIT]
      |=> mem_if.rd_data == $past(mem_if.rd_data) && acc_r == $past(alu_if.result);
  endproperty
  a_dest_w: assert property (p_dest_w) else $error("wrong destination");

  property p_carry_sum;
    exec && op_dec == ALD_OP_ADD_ACCUMULATOR_FILE_WITH_CARRY
      |=> ($past(cur_ins[`ALD_INS_DEST_BIT]) ? mem_if.rd_data : acc_r)
          == 8'($past(acc_r) + $past(mem_if.rd_data) + {7'h00, $past(flg_r.cy)});
  endproperty
  a_carry_sum: assert property (p_carry_sum) else $error("carry sum wrong");

  property p_bank;
    exec && is_reg && cur_ins[`ALD_INS_BANKSEL_BIT]
      |=> ea_r == {$past(bank_r), $past(fld)};
  endproperty
  a_bank: assert property (p_bank) else $error("banked address wrong");

  property p_access;
    exec && is_reg && !cur_ins[`ALD_INS_BANKSEL_BIT] && !ext_r
      |=> ea_r[11:8] == (($past(fld) <= `ALD_ILO_MAX) ? `ALD_ACCESS_LO_BANK
                                                      : `ALD_ACCESS_HI_BANK);
  endproperty
  a_access: assert property (p_access) else $error("access address wrong");

  property p_indexed;
    exec && is_reg && !cur_ins[`ALD_INS_BANKSEL_BIT] && ext_r && fld <= `ALD_ILO_MAX
      |=> ea_r == $past(ibase_r) + {4'h0, $past(fld)};
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_and_lit;
    exec && op_dec == ALD_OP_AND_LITERAL_WITH_ACCUMULATOR
      |=> acc_r == ($past(acc_r) & $past(fld)) && flg_r.cy == $past(flg_r.cy)
          && flg_r.dcy == $past(flg_r.dcy) && flg_r.ovf == $past(flg_r.ovf);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

  property p_add_lit;
    exec && op_dec == ALD_OP_ADD_LITERAL_TO_ACCUMULATOR
      |=> acc_r == 8'($past(acc_r) + $past(fld))
          && flg_r.cy == (({1'b0, $past(acc_r)} + {1'b0, $past(fld)}) > 9'h0FF);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("add literal wrong");

  property p_zn_flags;
    exec && op_dec != ALD_OP_NONE && !(is_reg && cur_ins[`ALD_INS_DEST_BIT])
      |=> flg_r.zero == (acc_r == 8'h00) && flg_r.neg == acc_r[7];
  endproperty
  a_zn_flags: assert property (p_zn_flags) else $error("zero or negative wrong");

  property p_one_cycle;
    req && !ack_r |=> ACK_O ##1 !ACK_O;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("ack timing wrong");

endmodule

`default_nettype wire

//--- verilog/ald_regs.svh
`ifndef ALD_REGS_SVH
`define ALD_REGS_SVH

// ********************************************************
// register byte addresses on the wishbone port
// ********************************************************
`define ALD_ADR_INSTR 8'h00
`define ALD_ADR_ACCUM 8'h04
`define ALD_ADR_STATUS 8'h08
`define ALD_ADR_BANK 8'h0C
`define ALD_ADR_CTRL 8'h10
`define ALD_ADR_IBASE 8'h14
`define ALD_ADR_MPTR 8'h18
`define ALD_ADR_MDATA 8'h1C
`define ALD_ADR_INFO 8'h20

// ********************************************************
// field positions
// ********************************************************
`define ALD_CTRL_EXT_BIT 0
`define ALD_INFO_BAD_BIT 16
`define ALD_INS_DEST_BIT 9
`define ALD_INS_BANKSEL_BIT 8

// ********************************************************
// reset values
// ********************************************************
`define ALD_RST_ACCUM 8'h00
`define ALD_RST_STATUS 5'h00
`define ALD_RST_BANK 4'h0
`define ALD_RST_IBASE 12'h000
`define ALD_RST_INSTR 16'h0000

// ********************************************************
// opcodes and addressing limits
// ********************************************************
`define ALD_OPC_ADD_LITERAL_TO_ACCUMULATOR 8'h0F
`define ALD_OPC_AND_LITERAL_WITH_ACCUMULATOR 8'h0B
`define ALD_OPC_ADD_ACCUMULATOR_TO_FILE 6'h09
`define ALD_OPC_ADD_ACCUMULATOR_FILE_WITH_CARRY 6'h08
`define ALD_ILO_MAX 8'h5F
`define ALD_ACCESS_LO_BANK 4'h0
`define ALD_ACCESS_HI_BANK 4'hF

`endif

//--- verilog/ald_pkg.sv
package ald_pkg;

  // operations the datapath understands
  typedef enum logic [2:0] {
    ALD_OP_NONE,
    ALD_OP_ADD_LITERAL_TO_ACCUMULATOR,
    ALD_OP_AND_LITERAL_WITH_ACCUMULATOR,
    ALD_OP_ADD_ACCUMULATOR_TO_FILE,
    ALD_OP_ADD_ACCUMULATOR_FILE_WITH_CARRY
  } ald_op_e;

  // status flags, bit 0 is carry
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic dcy;
    logic cy;
  } ald_flags_s;

endpackage

//--- verilog/ald_if.sv
`timescale 1ns/100ps
`default_nettype none

// operands in, result and flags out
interface ald_alu_if;
  import ald_pkg::*;
  ald_op_e op;
  logic [7:0] acc;
  logic [7:0] opnd;
  ald_flags_s flags_in;
  logic [7:0] result;
  ald_flags_s flags_out;
  modport core (output op, acc, opnd, flags_in, input result, flags_out);
  modport alu (input op, acc, opnd, flags_in, output result, flags_out);
endinterface

// one read port, one write port into the file memory
interface ald_mem_if #(parameter int ADDR_W = 12);
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0] wr_data;
  modport core (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
  modport mem (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface

`default_nettype wire

//--- verilog/ald_alu.sv
`timescale 1ns/100ps
`default_nettype none

module ald_alu
  import ald_pkg::*;
(
  ald_alu_if.alu alu
);

  // ********************************************************
  // adder and logic unit, purely combinational
  // ********************************************************
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic cin;

  // carry only enters for the with-carry form
  always_comb begin
    cin = (alu.op == ALD_OP_ADD_ACCUMULATOR_FILE_WITH_CARRY) ? alu.flags_in.cy : 1'b0;
    sum9 = {1'b0, alu.acc} + {1'b0, alu.opnd} + {8'h00, cin};
    sum5 = {1'b0, alu.acc[3:0]} + {1'b0, alu.opnd[3:0]} + {4'h0, cin};
  end

  // flags left alone unless the operation owns them
  always_comb begin
    alu.result = alu.acc;
    alu.flags_out = alu.flags_in;
    case (alu.op)
      ALD_OP_ADD_LITERAL_TO_ACCUMULATOR,
      ALD_OP_ADD_ACCUMULATOR_TO_FILE,
      ALD_OP_ADD_ACCUMULATOR_FILE_WITH_CARRY: begin
        alu.result = sum9[7:0];
        alu.flags_out.cy = sum9[8];
        alu.flags_out.dcy = sum5[4];
        alu.flags_out.ovf = (alu.acc[7] == alu.opnd[7]) && (sum9[7] != alu.acc[7]);
        alu.flags_out.zero = (sum9[7:0] == 8'h00);
        alu.flags_out.neg = sum9[7];
      end
      ALD_OP_AND_LITERAL_WITH_ACCUMULATOR: begin
        alu.result = alu.acc & alu.opnd;
        alu.flags_out.zero = ((alu.acc & alu.opnd) == 8'h00);
        alu.flags_out.neg = alu.acc[7] & alu.opnd[7];
      end
      default: begin
      end
    endcase
  end

endmodule

`default_nettype wire

//--- verilog/ald_file_mem.sv
`timescale 1ns/100ps
`default_nettype none

module ald_file_mem #(
  parameter int ADDR_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  ald_mem_if.mem mem
);

  localparam int DEPTH = 1 << ADDR_W;

  logic [7:0] mem_r [DEPTH];

  // cleared at reset so that first reads are defined
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (mem.wr_en) begin
      mem_r[mem.wr_addr] <= mem.wr_data;
    end
  end

  // asynchronous read, so an operand is ready in the same cycle
  assign mem.rd_data = mem_r[mem.rd_addr];

endmodule

`default_nettype wire

//--- test/add_and_literal_alu_ops_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ald_regs.svh"

module add_and_literal_alu_ops_tb_top;
  import ald_pkg::*;

  logic CLK_I;
  logic SYS_RST_I;
  logic CYC_I;
  logic STB_I;
  logic WE_I;
  logic [7:0] ADR_I;
  logic [3:0] SEL_I;
  logic [31:0] DAT_I;
  logic [31:0] DAT_O;
  logic ACK_O;
  int fails;
  int compares;
  logic [31:0] exp_q[$];
  logic [31:0] seed;
  // reference state of the datapath, kept by the bench
  logic [7:0] acc;
  logic [7:0] mem [0:4095];
  logic [4:0] st;
  logic [3:0] bank;
  logic ext;
  logic [11:0] ibase;
  logic [11:0] info_ea;
  logic bad;

  ald_core #(.MEM_ADDR_W(12)) u_dut (
    .CLK_I(CLK_I),
    .SYS_RST_I(SYS_RST_I),
    .CYC_I(CYC_I),
    .STB_I(STB_I),
    .WE_I(WE_I),
    .ADR_I(ADR_I),
    .SEL_I(SEL_I),
    .DAT_I(DAT_I),
    .DAT_O(DAT_O),
    .ACK_O(ACK_O)
  );

  // ********************************************************
  // clock, verdict and watchdog
  // ********************************************************
  initial begin
    CLK_I = 1'b0;
    forever #12.5 CLK_I = ~CLK_I;
  end

  task automatic complete_run;
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // far longer than the ~6000 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge CLK_I);
    fails++;
    complete_run();
  end

  // ********************************************************
  // comparison and result monitor
  // ********************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // read data is taken at the very edge where ack is sampled high
  always @(posedge CLK_I) begin
    if (ACK_O === 1'b1 && WE_I === 1'b0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[FAIL] t=%0t seen=%h exp=none", $time, DAT_O);
      end else begin
        check(DAT_O, exp_q.pop_front());
      end
    end
  end

  // ********************************************************
  // bus master and reference model
  // ********************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // holds the whole request until ack is seen, then one idle cycle;
  // no cycle limit here, a hang is left to the watchdog
  task automatic wb_cyc(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge CLK_I);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= we;
    ADR_I <= adr;
    DAT_I <= dat;
    SEL_I <= 4'hF;
    @(posedge CLK_I);
    while (ACK_O !== 1'b1) begin
      @(posedge CLK_I);
    end
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_cyc(1'b1, adr, dat);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    exp_q.push_back(exp);
    wb_cyc(1'b0, adr, 32'h0000_0000);
  endtask

  function automatic logic [11:0] eff(input logic a, input logic [7:0] f);
    if (a) return {bank, f};
    if (ext && f <= 8'h5F) return ibase + {4'h0, f};
    if (f <= 8'h5F) return {4'h0, f};
    return {4'hF, f};
  endfunction

  // loads every piece of state the instruction reads, incl. the operand byte
  task automatic setup(input logic [7:0] a_v, input logic [4:0] s_v, input logic [3:0] b_v,
                       input logic e_v, input logic [11:0] i_v, input logic a,
                       input logic [7:0] f, input logic [7:0] m);
    acc = a_v;
    st = s_v;
    bank = b_v;
    ext = e_v;
    ibase = i_v;
    wr(`ALD_ADR_ACCUM, {24'h0, acc});
    wr(`ALD_ADR_STATUS, {27'h0, st});
    wr(`ALD_ADR_BANK, {28'h0, bank});
    wr(`ALD_ADR_CTRL, {31'h0, ext});
    wr(`ALD_ADR_IBASE, {20'h0, ibase});
    mem[eff(a, f)] = m;
    wr(`ALD_ADR_MPTR, {20'h0, eff(a, f)});
    wr(`ALD_ADR_MDATA, {24'h0, m});
  endtask

  // k: 0 add literal, 1 and literal, 2 add to file, 3 add with carry, 4 unsupported
  task automatic run_op(input logic [2:0] k, input logic [7:0] f, input logic d,
                        input logic a);
    logic [11:0] ea;
    logic [7:0] src;
    logic [7:0] res;
    logic [8:0] s;
    logic [4:0] h;
    logic cin;
    logic [15:0] w;
    ea = eff(a, f);
    src = (k <= 3'd1) ? f : mem[ea];
    cin = (k == 3'd3) ? st[0] : 1'b0;
    case (k)
      3'd0: w = {8'h0F, f};
      3'd1: w = {8'h0B, f};
      3'd2: w = {6'h09, d, a, f};
      3'd3: w = {6'h08, d, a, f};
      default: w = {8'hE0, f};
    endcase
    if (k == 3'd1) begin
      res = acc & f;
      st[4] = res[7];
      st[2] = (res == 8'h00);
      acc = res;
    end else if (k <= 3'd3) begin
      s = {1'b0, acc} + {1'b0, src} + {8'h00, cin};
      h = {1'b0, acc[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
      res = s[7:0];
      st = {res[7], (acc[7] == src[7]) && (res[7] != acc[7]), res == 8'h00, h[4], s[8]};
      if (k >= 3'd2 && d) mem[ea] = res;
      else acc = res;
    end
    if (k == 3'd2 || k == 3'd3) info_ea = ea;
    bad = (k > 3'd3);
    wr(`ALD_ADR_INSTR, {16'h0, w});
    rd(`ALD_ADR_ACCUM, {24'h0, acc});
    rd(`ALD_ADR_STATUS, {27'h0, st});
    rd(`ALD_ADR_INFO, {15'h0, bad, 4'h0, info_ea});
    rd(`ALD_ADR_MDATA, {24'h0, mem[ea]});
  endtask

  // ********************************************************
  // main sequence
  // ********************************************************
  initial begin
    logic [7:0] f;
    logic a_b;
    fails = 0;
    compares = 0;
    seed = 32'h3617;
    CYC_I = 1'b0;
    STB_I = 1'b0;
    WE_I = 1'b0;
    ADR_I = 8'h00;
    SEL_I = 4'h0;
    DAT_I = 32'h0000_0000;
    SYS_RST_I = 1'b1;
    for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    info_ea = 12'h000;
    bad = 1'b0;
    repeat (20) @(posedge CLK_I);
    SYS_RST_I <= 1'b0;
    @(posedge CLK_I);
    // reset values, plus an unmapped word that must read as zero
    rd(`ALD_ADR_ACCUM, 32'h0000_0000);
    rd(`ALD_ADR_STATUS, 32'h0000_0000);
    rd(`ALD_ADR_INFO, 32'h0000_0000);
    rd(8'h3C, 32'h0000_0000);
    // worked examples: 10h+15h, 4Dh+02h+carry, A3h and 5Fh
    setup(8'h10, 5'h00, 4'h0, 1'b0, 12'h000, 1'b0, 8'h15, 8'h00);
    run_op(3'd0, 8'h15, 1'b0, 1'b0);
    rd(`ALD_ADR_ACCUM, 32'h0000_0025);
    setup(8'h4D, 5'h01, 4'h3, 1'b0, 12'h000, 1'b1, 8'h40, 8'h02);
    run_op(3'd3, 8'h40, 1'b0, 1'b1);
    rd(`ALD_ADR_ACCUM, 32'h0000_0050);
    setup(8'hA3, 5'h0B, 4'h0, 1'b0, 12'h000, 1'b0, 8'h5F, 8'h00);
    run_op(3'd1, 8'h5F, 1'b0, 1'b0);
    rd(`ALD_ADR_STATUS, 32'h0000_000B);
    // random traffic, with the indexed-offset boundary 5Fh/60h forced often
    for (int i = 0; i < 150; i++) begin
      seed = xs(seed);
      f = (i % 4 == 0) ? 8'h5F : (i % 4 == 1) ? 8'h60 : seed[7:0];
      // same bank bit for setup and op, so the window pointer hits the operand
      a_b = seed[26];
      setup(seed[15:8], seed[20:16], seed[24:21], seed[25], seed[31:20], a_b, f,
            seed[23:16]);
      seed = xs(seed);
      run_op(3'(seed[7:0] % 5), f, seed[8], a_b);
    end
    repeat (3) @(posedge CLK_I);
    if (exp_q.size() != 0) fails++;
    complete_run();
  end
endmodule

`default_nettype wire
